/* rtl/bvs_pkg.sv */
// Package for the buck voltage setpoint register bank: map, fields, reset values, carriers
// Contract
// - Buck3 voltage control register sits at address 0x10 and resets to 0x08.
// - Buck voltage registers are password protected; writes need a completed unlock.
// - Bit 7 chooses register code (0) or external adjustment (1); resets to 0.
// - Bit 6 of each buck voltage register is reserved and reads zero.
// - Bits 5..0 hold the voltage code, reset 001000; codes 111000 and up mean 3.3 V.
// - Without auto update, new setpoints apply on the apply bit, cleared after transition.
package bvs_pkg;

   // Register addresses
   localparam logic [7:0] BVS_ADDR_BUCK2 = 8'h0F;
   localparam logic [7:0] BVS_ADDR_BUCK3 = 8'h10;
   localparam logic [7:0] BVS_ADDR_SLEW = 8'h11;

   // Field positions
   localparam int BVS_EXT_BIT = 7;
   localparam int BVS_RSVD_BIT = 6;
   localparam int BVS_CODE_MSB = 5;
   localparam int BVS_APPLY_BIT = 7;
   localparam int BVS_AUTO_BIT = 6;

   // Writable-bit mask of a buck voltage register: reserved bit 6 excluded
   localparam logic [7:0] BVS_BUCK_WMASK = 8'hBF;

   // Reset values and the top voltage code
   localparam logic [7:0] BVS_RST_BUCK3 = 8'h08;
   localparam logic [7:0] BVS_RST_BUCK2 = 8'h08;
   localparam logic [7:0] BVS_RST_SLEW = 8'h06;
   localparam logic [5:0] BVS_CODE_TOP = 6'h38;

   // Step timing: fastest timed step 3.5 us, slower codes double it
   localparam real BVS_STEP_BASE_US = 3.5;
   localparam real BVS_CLK_MHZ = 250.0;
   localparam int BVS_STEP_BASE_CYC = int'(BVS_STEP_BASE_US * BVS_CLK_MHZ);
   localparam logic [2:0] BVS_SLEW_IMMEDIATE = 3'h7;
   localparam logic [2:0] BVS_SLEW_FASTEST = 3'h6;

   // Register access request from the serial port's decoder
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] data;
   } bvs_req_t;

   // Per-converter output to the regulation loop
   typedef struct packed {
      logic extAdjust;
      logic [5:0] code;
      logic moving;
   } bvs_out_t;

endpackage

/* rtl/bvs_ramp.sv */
// Stepping engine that walks one converter's applied code toward its target
`timescale 1ns/1ps
module bvs_ramp
   import bvs_pkg::*;
#(
   parameter logic [5:0] RESET_CODE = 6'h08
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic load,
   input wire logic [5:0] target,
   input wire logic [16:0] stepCycles,
   output logic [5:0] code,
   output logic busy
);

   logic [5:0] goal;
   logic [16:0] count;

   assign busy = (code != goal);

   // Latch a new goal only when told to apply
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         goal <= RESET_CODE;
      end else if (load) begin
         goal <= target;
      end
   end

   // One code step per interval; a zero interval jumps straight to the goal
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         code <= RESET_CODE;
         count <= 17'h0_0000;
      end else if (!busy) begin
         count <= 17'h0_0000;
      end else if (stepCycles == 17'h0_0000) begin
         code <= goal;
      end else if (count >= stepCycles - 17'h0_0001) begin
         count <= 17'h0_0000;
         code <= (goal > code) ? code + 6'h01 : code - 6'h01;
      end else begin
         count <= count + 17'h0_0001;
      end
   end

endmodule

/* rtl/bvs_regs.sv */
// Buck2/buck3 voltage setpoint register bank with apply-bit driven transitions
`timescale 1ns/1ps
module bvs_regs
   import bvs_pkg::*;
#(
   parameter logic [7:0] BUCK2_RESET = BVS_RST_BUCK2,
   parameter int STEP_BASE_CYC = BVS_STEP_BASE_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire bvs_req_t req,
   input wire logic unlocked,
   output logic [7:0] rdData,
   output logic rdValid,
   output bvs_out_t buck2Out,
   output bvs_out_t buck3Out
);

   logic [7:0] buck2Reg;
   logic [7:0] buck3Reg;
   logic [7:0] slewReg;
   logic [7:0] next_buck2;
   logic [7:0] next_buck3;
   logic applyStarted;
   logic [1:0] rampBusy;
   logic [5:0] rampCode [2];
   logic [5:0] rampTarget [2];
   logic [16:0] stepCycles;
   logic loadRamps;
   logic wrBuck2;
   logic wrBuck3;
   logic wrSlew;

   // Protected writes only land once the password unlock has completed
   assign wrBuck2 = req.write && unlocked && req.addr == BVS_ADDR_BUCK2;
   assign wrBuck3 = req.write && unlocked && req.addr == BVS_ADDR_BUCK3;
   assign wrSlew = req.write && unlocked && req.addr == BVS_ADDR_SLEW;

   // Merge write data, masking the reserved bit so it can never become one
   always_comb begin
      next_buck2 = buck2Reg;
      next_buck3 = buck3Reg;
      if (wrBuck2) begin
         next_buck2 = req.data & BVS_BUCK_WMASK;
      end
      if (wrBuck3) begin
         next_buck3 = req.data & BVS_BUCK_WMASK;
      end
   end

   // Setpoint registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         buck2Reg <= BUCK2_RESET & BVS_BUCK_WMASK;
         buck3Reg <= BVS_RST_BUCK3;
      end else begin
         buck2Reg <= next_buck2;
         buck3Reg <= next_buck3;
      end
   end

   // Apply bit: host write sets it, hardware clears it when all ramps settle.
   // A host write in the clearing cycle wins, so a fresh request is never lost.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         slewReg <= BVS_RST_SLEW;
         applyStarted <= 1'b0;
      end else if (wrSlew) begin
         slewReg <= req.data;
         applyStarted <= 1'b0;
      end else if (slewReg[BVS_APPLY_BIT] && !applyStarted) begin
         applyStarted <= 1'b1;
      end else if (applyStarted && rampBusy == 2'b00) begin
         slewReg[BVS_APPLY_BIT] <= 1'b0;
         applyStarted <= 1'b0;
      end
   end

   // Goals reload on the apply bit, or continuously when auto update is on
   assign loadRamps = slewReg[BVS_AUTO_BIT] || (slewReg[BVS_APPLY_BIT] && !applyStarted);

   // Per-step interval from the slew code; the top code means no pacing
   always_comb begin
      if (slewReg[2:0] == BVS_SLEW_IMMEDIATE) begin
         stepCycles = 17'h0_0000;
      end else begin
         stepCycles = 17'(STEP_BASE_CYC) << (BVS_SLEW_FASTEST - slewReg[2:0]);
      end
   end

   assign rampTarget[0] = buck2Reg[BVS_CODE_MSB:0];
   assign rampTarget[1] = buck3Reg[BVS_CODE_MSB:0];

   // One stepping engine per converter
   for (genvar i = 0; i < 2; i++) begin : g_ramp
      bvs_ramp #(
         .RESET_CODE(i == 0 ? BUCK2_RESET[5:0] : BVS_RST_BUCK3[5:0])
      ) u_ramp (
         .clk(clk),
         .nrst(nrst),
         .load(loadRamps),
         .target(rampTarget[i]),
         .stepCycles(stepCycles),
         .code(rampCode[i]),
         .busy(rampBusy[i])
      );
   end

   // Converter outputs; external adjust is passed beside the code, which still follows the ramp
   assign buck2Out = '{extAdjust: buck2Reg[BVS_EXT_BIT], code: rampCode[0], moving: rampBusy[0]};
   assign buck3Out = '{extAdjust: buck3Reg[BVS_EXT_BIT], code: rampCode[1], moving: rampBusy[1]};

   // Registered read port; unmapped addresses read zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdData <= 8'h00;
         rdValid <= 1'b0;
      end else begin
         rdValid <= req.read;
         if (req.read) begin
            unique case (req.addr)
               BVS_ADDR_BUCK2: rdData <= buck2Reg;
               BVS_ADDR_BUCK3: rdData <= buck3Reg;
               BVS_ADDR_SLEW: rdData <= slewReg;
               default: rdData <= 8'h00;
            endcase
         end
      end
   end

endmodule

/* sim/bvs_regs_chk.sv */
// Port checker for the setpoint bank
`timescale 1ns/1ps
module bvs_regs_chk
   import bvs_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire bvs_req_t req,
   input wire logic unlocked,
   input wire logic [7:0] rdData,
   input wire logic rdValid,
   input wire bvs_out_t buck2Out,
   input wire bvs_out_t buck3Out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Apply write, then the ramp must settle in bounded time
   sequence applyWr;
      req.write && unlocked && req.addr == BVS_ADDR_SLEW && req.data[7];
   endsequence
   // Goals load one edge after the write; motion must end inside the bound
   sequence settled;
      ##[0:200] !buck3Out.moving;
   endsequence
   rst_value_a: assert property ($rose(nrst) |-> buck3Out.code == 6'h08 && !buck3Out.extAdjust)
      else $error("bad reset output");
   rd_latency_a: assert property (req.read |=> rdValid) else $error("late read");
   rd_source_a: assert property (rdValid |-> $past(req.read)) else $error("stray read");
   rd_hold_a: assert property (!rdValid |-> $stable(rdData)) else $error("read data moved");
   locked_wr_a: assert property (req.write && !unlocked && req.addr == BVS_ADDR_BUCK3
      |=> $stable(buck3Out.extAdjust)) else $error("locked write taken");
   ext_follow_a: assert property (req.write && unlocked && req.addr == BVS_ADDR_BUCK3
      |=> buck3Out.extAdjust == $past(req.data[7])) else $error("adjust bit lost");
   rsvd_zero_a: assert property (rdValid && $past(req.addr == BVS_ADDR_BUCK3 ||
      req.addr == BVS_ADDR_BUCK2) |-> !rdData[6]) else $error("reserved bit set");
   code_move_a: assert property ($changed(buck3Out.code) |-> $past(buck3Out.moving))
      else $error("code moved unasked");
   settle_a: assert property (applyWr |-> ##2 settled) else $error("ramp stuck");
   code_still_a: assert property (!buck3Out.moving |=> $stable(buck3Out.code))
      else $error("code moved at rest");
endmodule
bind bvs_regs bvs_regs_chk chk (.clk, .nrst, .req, .unlocked, .rdData, .rdValid, .buck2Out, .buck3Out);

/* sim/bvs_host.sv */
// Host model issuing register requests
`timescale 1ns/1ps
module bvs_host
   import bvs_pkg::*;
(
   input wire logic clk,
   output bvs_req_t req,
   output logic unlocked
);
   initial req = '0;
   initial unlocked = 1'b0;
   // One-cycle strobe; then address and data flip so stale values are never trusted
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= {w, !w, a, d};
      @(posedge clk);
      req <= {1'b0, 1'b0, ~a, ~d};
   endtask
   // Level from the password sequencer; writes before it are refused
   task automatic lock(input logic u);
      @(posedge clk);
      unlocked <= u;
   endtask
endmodule

/* sim/buck_voltage_setpoint_regs_bench.sv */
// Self-checking bench for the setpoint bank
`timescale 1ns/1ps
module buck_voltage_setpoint_regs_bench;
   import bvs_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   bvs_req_t req;
   logic unlocked, rdValid;
   logic [7:0] rdData, v, prev;
   bvs_out_t buck2Out, buck3Out;
   int err_count = 0, samples_checked = 0, cycles = 0;
   integer seed = 32'h40c5;
   logic [7:0] expQ[$];
   always #2 clk = ~clk;
   bvs_host host (.clk, .req, .unlocked);
   // Short step base keeps ramps within a few hundred cycles
   bvs_regs #(.STEP_BASE_CYC(2)) dut (.clk, .nrst, .req, .unlocked, .rdData, .rdValid, .buck2Out, .buck3Out);
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rdx(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      host.xfer(1'b0, a, 8'h00);
   endtask
   task final_report;
      $display("checked %0d, errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Oldest note is matched against each read answer
   always @(posedge clk) begin
      if (rdValid === 1'b1) cmp(rdData, expQ.pop_front());
   end
   // Hang guard, well beyond the scenario length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      prev = BVS_RST_BUCK3;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rdx(BVS_ADDR_BUCK3, BVS_RST_BUCK3);
      rdx(BVS_ADDR_BUCK2, BVS_RST_BUCK2);
      host.xfer(1'b1, BVS_ADDR_BUCK3, 8'hFF);
      rdx(BVS_ADDR_BUCK3, BVS_RST_BUCK3);
      host.lock(1'b1);
      host.xfer(1'b1, BVS_ADDR_BUCK3, 8'hFF);
      rdx(BVS_ADDR_BUCK3, 8'hBF);
      // Random setpoints, applied alternately stepped and immediate
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         host.xfer(1'b1, BVS_ADDR_BUCK3, v);
         rdx(BVS_ADDR_BUCK3, v & BVS_BUCK_WMASK);
         cmp({2'h0, buck3Out.code}, prev);
         host.xfer(1'b1, BVS_ADDR_SLEW, {5'h10, 2'h3, i[0]});
         repeat (2) @(negedge clk);
         for (int k = 0; k < 300 && buck3Out.moving !== 1'b0; k++) @(negedge clk);
         prev = {2'h0, v[5:0]};
         cmp({2'h0, buck3Out.code}, prev);
         repeat (2) @(posedge clk);
         rdx(BVS_ADDR_SLEW, {7'h03, i[0]});
      end
      // Auto update: setpoints take effect with no apply bit
      host.xfer(1'b1, BVS_ADDR_SLEW, 8'h47);
      host.xfer(1'b1, BVS_ADDR_BUCK3, 8'h95);
      host.xfer(1'b1, BVS_ADDR_BUCK2, 8'hE3);
      rdx(BVS_ADDR_BUCK2, 8'hA3);
      @(negedge clk);
      cmp({buck3Out.extAdjust, 1'b0, buck3Out.code}, 8'h95);
      cmp({buck2Out.extAdjust, 1'b0, buck2Out.code}, 8'hA3);
      // Mid-run reset must bring the applied setpoint back as well
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rdx(BVS_ADDR_BUCK3, BVS_RST_BUCK3);
      @(negedge clk);
      cmp({buck3Out.extAdjust, 1'b0, buck3Out.code}, BVS_RST_BUCK3);
      repeat (3) @(posedge clk);
      final_report();
   end
endmodule
